// file: rtl/addr_map_cfg.svh
// Purpose: Address map, field positions and reset values of the map.
// Assumes: Byte addresses on the data side, word addresses on the program.
// Notes: Definitions only.
`ifndef ADDR_MAP_CFG_SVH
`define ADDR_MAP_CFG_SVH

// Core clock rate in hertz.
`define CORE_CLK_HZ 25000000

// Data side, 15-bit byte addresses.
`define D_WIN_END 15'h4000
`define D_REG_BASE 15'h4000
`define D_REG_END 15'h5000
`define D_INFO_BASE 15'h5000
`define D_INFO_END 15'h5400
`define D_RAM_BASE 15'h6c00
// Bit of the data address that marks a byte access.
`define D_BYTE_BIT 15

// Offsets inside the register region.
`define R_SYS_BASE 12'hc00
`define R_WIN_SEL 12'hf00
`define R_PERM_BASE 12'hf10
`define R_PERM_END 12'hf24

// Program side, 16-bit word addresses.
`define P_FLASH_END 16'he000
`define P_RAM_BASE 16'hf600

// Reset values.
`define WIN_SEL_RST 3'h0
`define PERM_RST 16'h0000

`endif

// file: rtl/addr_map_pkg.sv
// Purpose: Types shared by the address map and its permission store.
// Assumes: Nothing beyond the configuration header.
// Notes: Constants live in addr_map_cfg.svh.
package addr_map_pkg;

  // Source of a pending read answer.
  typedef enum logic [2:0] {
    SRC_NONE  = 3'b000,
    SRC_FLASH = 3'b001,
    SRC_INFO  = 3'b010,
    SRC_RAM   = 3'b011,
    SRC_REG   = 3'b100,
    SRC_LOCAL = 3'b101
  } src_e;

  // Reason a write was refused.
  typedef enum logic [1:0] {
    FLT_RAM  = 2'b00,
    FLT_SYS  = 2'b01,
    FLT_LOCK = 2'b10,
    FLT_BYTE = 2'b11
  } fault_kind_e;

endpackage

// file: rtl/ram_guard.sv
// Purpose: Per-section RAM write permission bits with word readback.
// Assumes: Writes come from the privileged path already checked upstream.
// Notes: A set bit lets restricted code write that 32-byte section.
`timescale 1ns/10ps
`include "addr_map_cfg.svh"
module ram_guard import addr_map_pkg::*; #(
  parameter int SECTIONS = 160
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic wr_i,
  input wire logic [3:0] wr_word_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [7:0] sect_i,
  output logic allow_o,
  input wire logic [3:0] rd_word_i,
  output logic [15:0] rd_data_o
);

  localparam int WORDS = (SECTIONS + 15) / 16;
  // Reset pattern of one permission word, repeated over every word.
  localparam logic [15:0] PERM_INIT = `PERM_RST;

  logic [WORDS*16-1:0] perm;

  // One permission flop per section, loaded by a word write.
  for (genvar g = 0; g < WORDS * 16; g++) begin : g_perm
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        perm[g] <= PERM_INIT[g % 16];
      end else if (wr_i && (wr_word_i == 4'(g / 16))) begin
        perm[g] <= wr_data_i[g % 16];
      end
    end
  end

  // Section lookup and readback; words past the store read as zero.
  always_comb begin
    allow_o = (32'(sect_i) < SECTIONS) ? perm[sect_i] : 1'b0;
    if (32'(rd_word_i) < WORDS) begin
      rd_data_o = perm[rd_word_i*16 +: 16];
    end else begin
      rd_data_o = 16'h0000;
    end
  end

endmodule

// file: rtl/cpu_address_map_and_write_guard.sv
// Purpose: Program and data address decode with restricted-level write guard.
// Assumes: Memories answer one cycle after their strobe.
// Notes: Answers reach the core three cycles after the request.
// Function
// - Data addresses are 15-bit byte addresses, byte or word access.
// - Program addresses are 16-bit word addresses, always whole words.
// - Data address bit 15 marks a byte access; core drives it always.
// - Flash is 128kB, handled as 1024-byte pages.
// - Lowest 112kB of flash sits at program words 0 to 56k.
// - Data window at lowest 16kB shows one of eight flash sections.
// - Data flash reads may be bytes; writes only whole words.
// - Top 16kB of flash reachable on data side only through the window.
// - Info page at 0x5000, 1024 bytes, byte read, word write.
// - Info page programming stays locked unless debug interface unlocks it.
// - RAM sits at the top 2.5k program words.
// - RAM occupies the last 5kB of data addresses.
// - Each 32-byte RAM section has a restricted-level write permission bit.
// - RAM reads never blocked; privileged level always has full access.
// - Peripheral registers start at data byte address 0x4000.
// - System registers refuse writes at the restricted level.
// - Blocked restricted writes are captured with their address.
// - Core and decoder run from the single core clock.
`timescale 1ns/10ps
`include "addr_map_cfg.svh"
module cpu_address_map_and_write_guard import addr_map_pkg::*; #(
  parameter int RAM_SECTIONS = 160
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic prog_req_i,
  input wire logic [15:0] prog_addr_i,
  input wire logic [15:0] pflash_rdata_i,
  input wire logic [15:0] pram_rdata_i,
  input wire logic data_req_i,
  input wire logic data_we_i,
  input wire logic [15:0] data_addr_i,
  input wire logic [15:0] data_wdata_i,
  input wire logic priv_i,
  input wire logic [15:0] dflash_rdata_i,
  input wire logic [15:0] info_rdata_i,
  input wire logic [15:0] ram_rdata_i,
  input wire logic [15:0] reg_rdata_i,
  input wire logic info_unlock_i,
  input wire logic fault_clr_i,
  output logic pflash_rd_o,
  output logic [15:0] pflash_addr_o,
  output logic pram_rd_o,
  output logic [11:0] pram_addr_o,
  output logic [15:0] prog_rdata_o,
  output logic prog_rvalid_o,
  output logic dflash_rd_o,
  output logic dflash_wr_o,
  output logic [15:0] dflash_addr_o,
  output logic info_rd_o,
  output logic info_wr_o,
  output logic [8:0] info_addr_o,
  output logic ram_rd_o,
  output logic ram_wr_o,
  output logic [11:0] ram_addr_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [10:0] reg_addr_o,
  output logic [15:0] wdata_o,
  output logic [1:0] be_o,
  output logic [15:0] data_rdata_o,
  output logic data_rvalid_o,
  output logic [2:0] win_sel_o,
  output logic info_prog_en_o,
  output logic fault_valid_o,
  output logic [15:0] fault_addr_o,
  output logic [1:0] fault_kind_o
);

  // Decoded data access, cycle 0.
  logic [14:0] a;
  logic is_byte;
  logic in_win;
  logic in_reg;
  logic in_info;
  logic in_ram;
  logic in_sys;
  logic in_local;
  logic [11:0] roff;
  logic [12:0] ram_off;
  logic [11:0] pram_off;
  logic allow;
  logic [15:0] perm_rd;
  logic [1:0] next_be;
  logic wr_flash;
  logic wr_info;
  logic wr_ram;
  logic wr_reg;
  logic wr_win;
  logic wr_perm;
  logic blocked;
  fault_kind_e next_kind;
  logic [15:0] local_rd;

  // Synchroniser for the debug unlock level.
  logic [2:0] unlock_sync;

  // Read answer pipeline.
  src_e src1;
  src_e src2;
  logic byte1;
  logic byte2;
  logic lane1;
  logic lane2;
  logic [15:0] local1;
  logic [15:0] local2;
  logic drd1;
  logic drd2;
  logic prd1;
  logic prd2;
  logic pram1;
  logic pram2;
  logic pmap1;
  logic pmap2;

  // Field extraction; bit 15 is the byte flag, not part of the address.
  assign a = data_addr_i[14:0];
  assign is_byte = data_addr_i[`D_BYTE_BIT];
  assign roff = a[11:0];
  assign ram_off = 13'(a - `D_RAM_BASE);
  assign pram_off = 12'(prog_addr_i - `P_RAM_BASE);

  // Region decode of the data side.
  always_comb begin
    in_win = (a < `D_WIN_END);
    in_reg = (a >= `D_REG_BASE) && (a < `D_REG_END);
    in_info = (a >= `D_INFO_BASE) && (a < `D_INFO_END);
    in_ram = (a >= `D_RAM_BASE);
    in_sys = in_reg && (roff >= `R_SYS_BASE);
    in_local = in_reg && (roff >= `R_WIN_SEL) && (roff < `R_PERM_END);
  end

  // Byte lanes: a byte access picks the lane from address bit 0.
  always_comb begin
    if (is_byte) begin
      next_be = a[0] ? 2'b10 : 2'b01;
    end else begin
      next_be = 2'b11;
    end
  end

  // Permission store for the RAM sections.
  ram_guard #(
    .SECTIONS(RAM_SECTIONS)
  ) u_guard (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .wr_i(wr_perm),
    .wr_word_i(4'(roff[11:1] - `R_PERM_BASE / 2)),
    .wr_data_i(data_wdata_i),
    .sect_i(ram_off[12:5]),
    .allow_o(allow),
    .rd_word_i(4'(roff[11:1] - `R_PERM_BASE / 2)),
    .rd_data_o(perm_rd)
  );

  // Readback of the locally held registers.
  always_comb begin
    if (roff == `R_WIN_SEL) begin
      local_rd = {13'h0000, win_sel_o};
    end else if (roff >= `R_PERM_BASE) begin
      local_rd = perm_rd;
    end else begin
      local_rd = 16'h0000;
    end
  end

  // Write decision and refusal reason for the current data access.
  always_comb begin
    wr_flash = 1'b0;
    wr_info = 1'b0;
    wr_ram = 1'b0;
    wr_reg = 1'b0;
    wr_win = 1'b0;
    wr_perm = 1'b0;
    blocked = 1'b0;
    next_kind = FLT_RAM;
    if (data_req_i && data_we_i) begin
      if (in_win) begin
        if (is_byte) begin
          blocked = 1'b1;
          next_kind = FLT_BYTE;
        end else begin
          wr_flash = 1'b1;
        end
      end else if (in_info) begin
        if (is_byte) begin
          blocked = 1'b1;
          next_kind = FLT_BYTE;
        end else if (!info_prog_en_o) begin
          blocked = 1'b1;
          next_kind = FLT_LOCK;
        end else begin
          wr_info = 1'b1;
        end
      end else if (in_ram) begin
        if (!priv_i && !allow) begin
          blocked = 1'b1;
          next_kind = FLT_RAM;
        end else begin
          wr_ram = 1'b1;
        end
      end else if (in_reg) begin
        if (!priv_i && in_sys) begin
          blocked = 1'b1;
          next_kind = FLT_SYS;
        end else if (in_local) begin
          wr_win = !is_byte && (roff == `R_WIN_SEL);
          wr_perm = !is_byte && (roff >= `R_PERM_BASE);
        end else begin
          wr_reg = 1'b1;
        end
      end
    end
  end

  // Debug unlock arrives from another domain; two agreeing stages count.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      unlock_sync <= 3'h0;
      info_prog_en_o <= 1'b0;
    end else begin
      unlock_sync <= {unlock_sync[1:0], info_unlock_i};
      if (unlock_sync[1] == unlock_sync[2]) begin
        info_prog_en_o <= unlock_sync[2];
      end
    end
  end

  // Flash window section select, privileged writes only.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      win_sel_o <= `WIN_SEL_RST;
    end else if (wr_win) begin
      win_sel_o <= data_wdata_i[2:0];
    end
  end

  // Refused write capture; a new refusal wins over a clear.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_valid_o <= 1'b0;
      fault_addr_o <= 16'h0000;
      fault_kind_o <= 2'h0;
    end else if (blocked) begin
      fault_valid_o <= 1'b1;
      fault_addr_o <= data_addr_i;
      fault_kind_o <= next_kind;
    end else if (fault_clr_i) begin
      fault_valid_o <= 1'b0;
    end
  end

  // Data side memory strobes, one cycle after the request.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dflash_rd_o <= 1'b0;
      dflash_wr_o <= 1'b0;
      dflash_addr_o <= 16'h0000;
      info_rd_o <= 1'b0;
      info_wr_o <= 1'b0;
      info_addr_o <= 9'h000;
      ram_rd_o <= 1'b0;
      ram_wr_o <= 1'b0;
      ram_addr_o <= 12'h000;
      reg_rd_o <= 1'b0;
      reg_wr_o <= 1'b0;
      reg_addr_o <= 11'h000;
      wdata_o <= 16'h0000;
      be_o <= 2'h0;
    end else begin
      dflash_rd_o <= data_req_i && !data_we_i && in_win;
      dflash_wr_o <= wr_flash;
      dflash_addr_o <= {win_sel_o, a[13:1]};
      info_rd_o <= data_req_i && !data_we_i && in_info;
      info_wr_o <= wr_info;
      info_addr_o <= a[9:1];
      ram_rd_o <= data_req_i && !data_we_i && in_ram;
      ram_wr_o <= wr_ram;
      ram_addr_o <= ram_off[12:1];
      reg_rd_o <= data_req_i && !data_we_i && in_reg && !in_local;
      reg_wr_o <= wr_reg;
      reg_addr_o <= roff[11:1];
      wdata_o <= data_wdata_i;
      be_o <= next_be;
    end
  end

  // Data read pipeline: source, lane and local value follow the strobe.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src1 <= SRC_NONE;
      src2 <= SRC_NONE;
      byte1 <= 1'b0;
      byte2 <= 1'b0;
      lane1 <= 1'b0;
      lane2 <= 1'b0;
      local1 <= 16'h0000;
      local2 <= 16'h0000;
      drd1 <= 1'b0;
      drd2 <= 1'b0;
    end else begin
      if (!data_req_i || data_we_i) begin
        src1 <= SRC_NONE;
      end else if (in_win) begin
        src1 <= SRC_FLASH;
      end else if (in_info) begin
        src1 <= SRC_INFO;
      end else if (in_ram) begin
        src1 <= SRC_RAM;
      end else if (in_local) begin
        src1 <= SRC_LOCAL;
      end else if (in_reg) begin
        src1 <= SRC_REG;
      end else begin
        src1 <= SRC_NONE;
      end
      byte1 <= is_byte;
      lane1 <= a[0];
      local1 <= local_rd;
      src2 <= src1;
      byte2 <= byte1;
      lane2 <= lane1;
      local2 <= local1;
      // Every read is answered, unmapped ones too, so the core never stalls.
      drd1 <= data_req_i && !data_we_i;
      drd2 <= drd1;
    end
  end

  // Data answer; flash, info and RAM byte reads land in the low byte, unmapped reads zero.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_rdata_o <= 16'h0000;
      data_rvalid_o <= 1'b0;
    end else begin
      data_rvalid_o <= drd2;
      case (src2)
        SRC_FLASH: data_rdata_o <= lane_pick(dflash_rdata_i, byte2, lane2);
        SRC_INFO: data_rdata_o <= lane_pick(info_rdata_i, byte2, lane2);
        SRC_RAM: data_rdata_o <= lane_pick(ram_rdata_i, byte2, lane2);
        SRC_REG: data_rdata_o <= reg_rdata_i;
        SRC_LOCAL: data_rdata_o <= local2;
        default: data_rdata_o <= 16'h0000;
      endcase
    end
  end

  // Program side strobes: flash words low, RAM words at the top.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pflash_rd_o <= 1'b0;
      pflash_addr_o <= 16'h0000;
      pram_rd_o <= 1'b0;
      pram_addr_o <= 12'h000;
    end else begin
      pflash_rd_o <= prog_req_i && (prog_addr_i < `P_FLASH_END);
      pflash_addr_o <= prog_addr_i;
      pram_rd_o <= prog_req_i && (prog_addr_i >= `P_RAM_BASE);
      pram_addr_o <= pram_off;
    end
  end

  // Program answer pipeline; the gap between regions reads zero.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prd1 <= 1'b0;
      prd2 <= 1'b0;
      pram1 <= 1'b0;
      pram2 <= 1'b0;
      pmap1 <= 1'b0;
      pmap2 <= 1'b0;
      prog_rdata_o <= 16'h0000;
      prog_rvalid_o <= 1'b0;
    end else begin
      prd1 <= prog_req_i;
      pram1 <= (prog_addr_i >= `P_RAM_BASE);
      pmap1 <= (prog_addr_i < `P_FLASH_END) || (prog_addr_i >= `P_RAM_BASE);
      prd2 <= prd1;
      pram2 <= pram1;
      pmap2 <= pmap1;
      prog_rvalid_o <= prd2;
      if (!pmap2) begin
        prog_rdata_o <= 16'h0000;
      end else if (pram2) begin
        prog_rdata_o <= pram_rdata_i;
      end else begin
        prog_rdata_o <= pflash_rdata_i;
      end
    end
  end

  // Selects one byte into the low lane for byte reads.
  function automatic logic [15:0] lane_pick(
    input logic [15:0] w,
    input logic b,
    input logic hi
  );
    if (!b) begin
      return w;
    end
    return hi ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction

  // Whole design runs on the one core clock.
  localparam int CLK_HZ = `CORE_CLK_HZ;

endmodule

// file: testbench/addr_map_monitor.sv
// Purpose: Timing and guard checks on the address map ports.
// Assumes: Memories answer the cycle after their strobe.
// Notes: Bound to the top module below.
`timescale 1ns/10ps
module addr_map_monitor (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic prog_req_i,
  input wire logic [15:0] prog_addr_i,
  input wire logic data_req_i,
  input wire logic data_we_i,
  input wire logic [15:0] data_addr_i,
  input wire logic priv_i,
  input wire logic pflash_rd_o,
  input wire logic [15:0] pflash_addr_o,
  input wire logic pram_rd_o,
  input wire logic [11:0] pram_addr_o,
  input wire logic prog_rvalid_o,
  input wire logic dflash_rd_o,
  input wire logic dflash_wr_o,
  input wire logic [15:0] dflash_addr_o,
  input wire logic info_rd_o,
  input wire logic info_wr_o,
  input wire logic ram_rd_o,
  input wire logic ram_wr_o,
  input wire logic [11:0] ram_addr_o,
  input wire logic reg_rd_o,
  input wire logic reg_wr_o,
  input wire logic data_rvalid_o,
  input wire logic [2:0] win_sel_o,
  input wire logic info_prog_en_o,
  input wire logic fault_valid_o,
  input wire logic [15:0] fault_addr_o,
  input wire logic [1:0] fault_kind_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [14:0] a;
  logic rd;
  logic wr;
  // Byte address and access kind of the current request.
  assign a = data_addr_i[14:0];
  assign rd = data_req_i && !data_we_i;
  assign wr = data_req_i && data_we_i;
  rd_latency_a: assert property (rd |-> ##3 data_rvalid_o)
    else $error("data read answer not in third cycle");
  fetch_latency_a: assert property (prog_req_i |-> ##3 prog_rvalid_o)
    else $error("fetch answer not in third cycle");
  flash_fetch_a: assert property (prog_req_i && prog_addr_i < 16'he000
    |=> pflash_rd_o && pflash_addr_o == $past(prog_addr_i))
    else $error("flash fetch address wrong");
  ram_fetch_a: assert property (prog_req_i && prog_addr_i >= 16'hf600
    |=> pram_rd_o && pram_addr_o == 12'($past(prog_addr_i) - 16'hf600))
    else $error("ram fetch address wrong");
  ram_read_a: assert property (rd && a >= 15'h6c00 |=> ram_rd_o
    && ram_addr_o == 12'(($past(a) - 15'h6c00) >> 1))
    else $error("ram read address wrong");
  win_read_a: assert property (rd && a < 15'h4000 |=> dflash_rd_o
    && dflash_addr_o == {$past(win_sel_o), $past(a[13:1])})
    else $error("window read address wrong");
  sys_guard_a: assert property (wr && !priv_i && !data_addr_i[15]
    && a >= 15'h4c00 && a < 15'h5000 |=> !reg_wr_o && fault_valid_o
    && fault_addr_o == $past(data_addr_i))
    else $error("restricted system write not refused");
  byte_flash_a: assert property (wr && data_addr_i[15] && a < 15'h4000
    |=> !dflash_wr_o && fault_valid_o && fault_kind_o == 2'h3)
    else $error("byte flash write not refused");
  info_lock_a: assert property (wr && a >= 15'h5000 && a < 15'h5400
    && !data_addr_i[15] && !info_prog_en_o |=> !info_wr_o
    && fault_kind_o == 2'h2)
    else $error("locked info write not refused");
  unmapped_a: assert property (data_req_i && a >= 15'h5400
    && a < 15'h6c00 |=> !(ram_rd_o || ram_wr_o || reg_rd_o || reg_wr_o
    || info_rd_o || info_wr_o || dflash_rd_o || dflash_wr_o))
    else $error("unmapped access reached a memory");
  // Main scenarios seen.
  ram_wr_c: cover property (wr && !priv_i && a >= 15'h6c00 ##1 ram_wr_o);
  info_wr_c: cover property (info_prog_en_o && info_wr_o);
  fault_c: cover property (fault_valid_o && fault_kind_o == 2'h1);
endmodule
bind cpu_address_map_and_write_guard addr_map_monitor mon (.*);

// file: testbench/mem_model.sv
// Purpose: Memories behind the map, answering the cycle after a strobe.
// Assumes: Read data is a fixed pattern of the word address.
// Notes: Idle read lines show the inverse of their last value.
`timescale 1ns/10ps
module mem_model (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic pflash_rd_o,
  input wire logic [15:0] pflash_addr_o,
  input wire logic pram_rd_o,
  input wire logic [11:0] pram_addr_o,
  input wire logic dflash_rd_o,
  input wire logic [15:0] dflash_addr_o,
  input wire logic info_rd_o,
  input wire logic [8:0] info_addr_o,
  input wire logic ram_rd_o,
  input wire logic [11:0] ram_addr_o,
  input wire logic reg_rd_o,
  input wire logic [10:0] reg_addr_o,
  output logic [15:0] pflash_rdata_i,
  output logic [15:0] pram_rdata_i,
  output logic [15:0] dflash_rdata_i,
  output logic [15:0] info_rdata_i,
  output logic [15:0] ram_rdata_i,
  output logic [15:0] reg_rdata_i
);
  // Each memory returns its word one cycle after the strobe.
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pflash_rdata_i <= 16'h0000;
      pram_rdata_i <= 16'h0000;
      dflash_rdata_i <= 16'h0000;
      info_rdata_i <= 16'h0000;
      ram_rdata_i <= 16'h0000;
      reg_rdata_i <= 16'h0000;
    end else begin
      pflash_rdata_i <= pflash_rd_o ? pflash_addr_o ^ 16'h1111
        : ~pflash_rdata_i;
      pram_rdata_i <= pram_rd_o ? {4'h2, pram_addr_o} : ~pram_rdata_i;
      dflash_rdata_i <= dflash_rd_o ? dflash_addr_o ^ 16'h3333
        : ~dflash_rdata_i;
      info_rdata_i <= info_rd_o ? {7'h22, info_addr_o} : ~info_rdata_i;
      ram_rdata_i <= ram_rd_o ? {4'h5, ram_addr_o} : ~ram_rdata_i;
      reg_rdata_i <= reg_rd_o ? {5'h0c, reg_addr_o} : ~reg_rdata_i;
    end
  end
endmodule

// file: testbench/cpu_address_map_and_write_guard_test.sv
// Purpose: Self-checking bench for the address map and write guard.
// Assumes: Core side driven on the falling edge.
// Notes: Memory words come from mem_model patterns.
`timescale 1ns/10ps
module cpu_address_map_and_write_guard_test import addr_map_pkg::*;;
  logic ref_clk_i, arst_n_i, prog_req_i, data_req_i, data_we_i, priv_i;
  logic info_unlock_i, fault_clr_i;
  logic [15:0] prog_addr_i, data_addr_i, data_wdata_i;
  logic [15:0] pflash_rdata_i, pram_rdata_i, dflash_rdata_i, info_rdata_i;
  logic [15:0] ram_rdata_i, reg_rdata_i;
  logic pflash_rd_o, pram_rd_o, prog_rvalid_o, dflash_rd_o, dflash_wr_o;
  logic info_rd_o, info_wr_o, ram_rd_o, ram_wr_o, reg_rd_o, reg_wr_o;
  logic data_rvalid_o, info_prog_en_o, fault_valid_o;
  logic [15:0] pflash_addr_o, prog_rdata_o, dflash_addr_o, wdata_o;
  logic [15:0] data_rdata_o, fault_addr_o;
  logic [11:0] pram_addr_o, ram_addr_o;
  logic [10:0] reg_addr_o;
  logic [8:0] info_addr_o;
  logic [2:0] win_sel_o;
  logic [1:0] be_o, fault_kind_o;
  int num_errors, check_count, cycles;
  cpu_address_map_and_write_guard dut (.*);
  mem_model mem (.*);
  // Clock at 25 MHz.
  initial begin
    ref_clk_i = 0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task acc(input logic we, input logic [15:0] ad, wd, input logic pv);
    @(negedge ref_clk_i);
    data_req_i = 1;
    data_we_i = we;
    data_addr_i = ad;
    data_wdata_i = wd;
    priv_i = pv;
    @(negedge ref_clk_i);
    data_req_i = 0;
  endtask
  task rd(input logic [15:0] ad, e);
    acc(0, ad, 16'h0000, 0);
    repeat (2) @(negedge ref_clk_i);
    chk("data_rvalid", 1, data_rvalid_o);
    chk(("data_rdata"), e, data_rdata_o);
  endtask
  task fetch(input logic [15:0] ad, e);
    @(negedge ref_clk_i);
    prog_req_i = 1;
    prog_addr_i = ad;
    @(negedge ref_clk_i);
    prog_req_i = 0;
    repeat (2) @(negedge ref_clk_i);
    chk("prog_rvalid", 1, prog_rvalid_o);
    chk("prog_rdata", e, prog_rdata_o);
  endtask
  // Checks the capture state, then clears it for one cycle.
  task flt(input logic v, input logic [1:0] k);
    chk("fault_valid", v, fault_valid_o);
    if (v) chk("fault_kind", k, fault_kind_o);
    fault_clr_i = 1;
    @(negedge ref_clk_i);
    fault_clr_i = 0;
  endtask
  task t_reads;
    rd(16'h6c04, 16'h5002);
    rd(16'hec05, 16'h0050);
    rd(16'hec04, 16'h0002);
    rd(16'h5002, 16'h4401);
    rd(16'h4002, 16'h6001);
    rd(16'h0006, 16'h3330);
    rd(16'h5400, 16'h0000);
  endtask
  task t_fetch;
    fetch(16'h0010, 16'h1101);
    fetch(16'hf601, 16'h2001);
    fetch(16'he000, 16'h0000);
  endtask
  task t_win;
    acc(1, 16'h4f00, 16'h0007, 1);
    chk("win_sel", 16'h0007, win_sel_o);
    rd(16'h4f00, 16'h0007);
    rd(16'h0002, 16'hd332);
    acc(1, 16'h0004, 16'hbeef, 0);
    chk("dflash_wr", 1, dflash_wr_o);
    chk("wdata", 16'hbeef, wdata_o);
    acc(1, 16'h4f00, 16'h0002, 0);
    chk("win_sel", 16'h0007, win_sel_o);
    chk("fault_addr", 16'h4f00, fault_addr_o);
    flt(1, 2'h1);
  endtask
  task t_guard;
    acc(1, 16'h6c00, 16'h1234, 0);
    chk("ram_wr", 0, ram_wr_o);
    chk("fault_addr", 16'h6c00, fault_addr_o);
    flt(1, 2'h0);
    acc(1, 16'h6c00, 16'h1234, 1);
    chk("ram_wr", 1, ram_wr_o);
    chk("wdata", 16'h1234, wdata_o);
    chk("be", 16'h0003, be_o);
    flt(0, 2'h0);
    acc(1, 16'h4f10, 16'h0001, 1);
    flt(0, 2'h0);
    rd(16'h4f10, 16'h0001);
    acc(1, 16'h6c00, 16'h1234, 0);
    chk("ram_wr", 1, ram_wr_o);
    flt(0, 2'h0);
    acc(1, 16'h6c20, 16'h1234, 0);
    flt(1, 2'h0);
    acc(1, 16'hec01, 16'h5500, 1);
    chk("be", 16'h0002, be_o);
    chk("ram_wr", 1, ram_wr_o);
    flt(0, 2'h0);
  endtask
  task t_sys;
    acc(1, 16'h4c00, 16'h0001, 0);
    chk("reg_wr", 0, reg_wr_o);
    flt(1, 2'h1);
    acc(1, 16'h4c00, 16'h0001, 1);
    chk("reg_wr", 1, reg_wr_o);
    flt(0, 2'h0);
    acc(1, 16'h5000, 16'h0001, 1);
    flt(1, 2'h2);
    info_unlock_i = 1;
    repeat (5) @(negedge ref_clk_i);
    chk("info_prog_en", 1, info_prog_en_o);
    acc(1, 16'h5000, 16'h0001, 1);
    chk("info_wr", 1, info_wr_o);
    flt(0, 2'h0);
    acc(1, 16'h8000, 16'h0001, 1);
    flt(1, 2'h3);
    acc(1, 16'h5400, 16'h0001, 1);
    flt(0, 2'h0);
  endtask
  task finish_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      finish_test;
    end
  end
  // Reset, then the scenarios in turn.
  initial begin
    {prog_req_i, data_req_i, data_we_i, priv_i} = 4'h0;
    {info_unlock_i, fault_clr_i} = 2'h0;
    prog_addr_i = 16'h0000;
    data_addr_i = 16'h0000;
    data_wdata_i = 16'h0000;
    arst_n_i = 0;
    repeat (8) @(negedge ref_clk_i);
    arst_n_i = 1;
    t_reads;
    t_fetch;
    t_win;
    t_guard;
    t_sys;
    finish_test;
  end
endmodule
